// ==== rtl/mac_pkg.sv ====
// package with alarm codes, blink counts, timing and carrier types
package mac_pkg;
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned BLINK_MS   = 250;
  localparam int unsigned GAP_MS     = 1500;
  localparam int unsigned BLINK_CYC  = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned GAP_CYC    = CLK_HZ / 1000 * GAP_MS;

  localparam logic [7:0] CODE_NONE      = 8'h00;
  localparam logic [7:0] CODE_DEVIATION = 8'h10;
  localparam logic [7:0] CODE_OVERHEAT  = 8'h21;
  localparam logic [7:0] CODE_OVERVOLT  = 8'h22;
  localparam logic [7:0] CODE_OVERLOAD  = 8'h30;
  localparam logic [7:0] CODE_NVMEM     = 8'h41;
  localparam logic [7:0] CODE_LIM_BOTH  = 8'h60;
  localparam logic [7:0] CODE_LIM_REV   = 8'h61;
  localparam logic [7:0] CODE_HOME_FAIL = 8'h62;
  localparam logic [7:0] CODE_NO_HOME   = 8'h63;
  localparam logic [7:0] CODE_AUX_MISS  = 8'h64;
  localparam logic [7:0] CODE_HW_OT     = 8'h66;
  localparam logic [7:0] CODE_SW_OT     = 8'h67;
  localparam logic [7:0] CODE_PANIC     = 8'h68;
  localparam logic [7:0] CODE_OFS_LIM   = 8'h6a;
  localparam logic [7:0] CODE_PARAM     = 8'h70;
  localparam logic [7:0] CODE_SYS       = 8'hf0;
  localparam logic [7:0] CODE_MEM       = 8'hf1;
  localparam logic [7:0] CODE_SEQ       = 8'hf2;

  localparam logic [3:0] BLINK_HOME   = 4'h7;
  localparam logic [3:0] BLINK_DEV    = 4'h4;
  localparam logic [3:0] BLINK_PANIC  = 4'h6;
  localparam logic [3:0] BLINK_LOAD   = 4'h2;
  localparam logic [3:0] BLINK_VOLT   = 4'h3;
  localparam logic [3:0] BLINK_NVMEM  = 4'h9;
  localparam logic [3:0] BLINK_STEADY = 4'hf;
  localparam logic [3:0] BLINK_NONE   = 4'h0;

  localparam logic [3:0] LOG_DEPTH    = 4'h8;

  // raw fault causes sampled from sensors and motion engine
  typedef struct packed {
    logic lim_both;
    logic lim_rev;
    logic home_fail;
    logic no_home;
    logic aux_miss;
    logic ofs_lim;
    logic param_err;
    logic deviation;
    logic panic;
    logic hw_ot;
    logic sw_ot;
    logic overheat;
    logic overload;
    logic overvolt;
    logic nvmem;
    logic sys_err;
    logic mem_err;
    logic seq_err;
  } mac_cause_t;

  // classification of one alarm
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] blinks;
    logic       cut_current;
  } mac_class_t;
endpackage : mac_pkg

// ==== rtl/mac_log_mem.sv ====
// small memory holding recent alarm codes, registered read data
`timescale 1ns/1ps
module mac_log_mem
  import mac_pkg::*;
#(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem_q [DEPTH];

  // write port, no reset on storage
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // registered read data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= CODE_NONE;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule : mac_log_mem

// ==== rtl/mac_alarm_classifier.sv ====
// protective alarm classifier: fault detection, code latch, led blinking
`timescale 1ns/1ps
// Notes on behaviour
// - both travel limits active together raises 0x60, stops motion and sequence.
// - limit opposite the seek direction during homing raises 0x61.
// - unstable or unexpected limit while homing raises 0x62.
// - homing travels between both limits without home sensor raises 0x63.
// - homing method needs slot, timing or index with home; none seen gives 0x64.
// - homing and limit group stops motion and sequence, blinks seven times.
// - limit active during offset move after homing raises 0x6a.
// - motion started with inconsistent parameters raises 0x70.
// - deviation reaches threshold with action set to alarm raises 0x10, four blinks.
// - emergency halt by input or command raises 0x68, six blinks.
// - travel limit during normal motion raises hardware over-travel and stops.
// - commanded position outside software limits raises 0x67.
// - drive temperature above limit raises 0x21 and removes current.
// - load above max torque accumulates; exceeding limit raises 0x30, two blinks.
// - supply overvoltage raises 0x22, three blinks.
// - non-volatile user data corruption raises 0x41, nine blinks.
// - unexpected internal state raises 0xf0, led lit steadily.
// - memory access failure raises 0xf1, bad sequence code raises 0xf2.
// - heat, load, voltage, memory and internal alarms cut motor current.
// - any alarm drives fault output off and stops the motor.
// - alarm clear input pulsed on then off resets at the falling edge.
module mac_alarm_classifier
  import mac_pkg::*;
#(
  parameter int unsigned POS_W     = 32,
  parameter int unsigned LOAD_W    = 24,
  parameter int unsigned TEMP_W    = 10,
  parameter int unsigned BLINK_CNT = BLINK_CYC,
  parameter int unsigned GAP_CNT   = GAP_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [1:0]        travel_limit_in,
  input  wire logic              limit_contact_polarity,
  input  wire logic              home_sensor_in,
  input  wire logic              slot_sensor_in,
  input  wire logic              timing_position_sig,
  input  wire logic              index_pulse_in,
  input  wire logic [1:0]        homing_method_select,
  input  wire logic              homing_active,
  input  wire logic              seek_dir_pos,
  input  wire logic              offset_move_active,
  input  wire logic              moving,
  input  wire logic              motion_start,
  input  wire logic              motion_param_bad,
  input  wire logic [POS_W-1:0]  deviation_abs,
  input  wire logic [POS_W-1:0]  deviation_threshold,
  input  wire logic              deviation_action,
  input  wire logic              emergency_halt,
  input  wire logic              emergency_halt_cmd,
  input  wire logic              fault_action_select,
  input  wire logic              sw_limit_enable,
  input  wire logic signed [POS_W-1:0] cmd_position,
  input  wire logic signed [POS_W-1:0] sw_limit_pos,
  input  wire logic signed [POS_W-1:0] sw_limit_neg,
  input  wire logic [TEMP_W-1:0] drive_temp,
  input  wire logic [TEMP_W-1:0] drive_temp_limit,
  input  wire logic [LOAD_W-1:0] load_excess,
  input  wire logic [LOAD_W-1:0] overload_limit,
  input  wire logic              supply_over,
  input  wire logic              nvmem_corrupt,
  input  wire logic              internal_state_bad,
  input  wire logic              mem_access_fail,
  input  wire logic              seq_code_bad,
  input  wire logic              fault_clear_in,
  input  wire logic [2:0]        log_rd_addr,
  output logic                   fault_output,
  output logic                   alarm_active,
  output logic [7:0]             alarm_code,
  output logic [3:0]             alarm_blinks,
  output logic                   stop_motion,
  output logic                   cut_current,
  output logic                   alarm_led,
  output logic [7:0]             log_rd_data
);
  typedef enum logic [1:0] {LED_IDLE, LED_ON, LED_OFF, LED_GAP} mac_led_t;

  localparam int unsigned CNT_W = $clog2(GAP_CNT + 1);
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CNT - 1);
  localparam logic [CNT_W-1:0] GAP_LAST   = CNT_W'(GAP_CNT - 1);

  logic [1:0]       lim_act;
  logic             home_seen_q;
  logic             aux_seen_q;
  logic [1:0]       lim_prev_q;
  logic [1:0]       lim_hit_q;
  logic [LOAD_W:0]  load_acc_q;
  logic             clr_prev_q;
  logic             clr_fall;
  mac_cause_t       cause;
  mac_class_t       cls;
  logic             latched_q;
  logic [7:0]       code_q;
  logic [3:0]       blinks_q;
  logic             cut_q;
  mac_led_t         led_q;
  logic [CNT_W-1:0] tmr_q;
  logic [3:0]       pulse_q;
  logic             led_q_out;
  logic [2:0]       log_wp_q;

  // classify a cause vector into code, blinks and stop class, highest severity first
  function automatic mac_class_t classify(input mac_cause_t c, input logic keep_sel);
    mac_class_t r;
    r = '{code: CODE_NONE, blinks: BLINK_NONE, cut_current: 1'b0};
    if (c.sys_err)        r = '{CODE_SYS, BLINK_STEADY, 1'b1};
    else if (c.mem_err)   r = '{CODE_MEM, BLINK_STEADY, 1'b1};
    else if (c.seq_err)   r = '{CODE_SEQ, BLINK_STEADY, 1'b1};
    else if (c.nvmem)     r = '{CODE_NVMEM, BLINK_NVMEM, 1'b1};
    else if (c.overheat)  r = '{CODE_OVERHEAT, BLINK_LOAD, 1'b1};
    else if (c.overvolt)  r = '{CODE_OVERVOLT, BLINK_VOLT, 1'b1};
    else if (c.overload)  r = '{CODE_OVERLOAD, BLINK_LOAD, 1'b1};
    else if (c.lim_both)  r = '{CODE_LIM_BOTH, BLINK_HOME, 1'b0};
    else if (c.lim_rev)   r = '{CODE_LIM_REV, BLINK_HOME, 1'b0};
    else if (c.home_fail) r = '{CODE_HOME_FAIL, BLINK_HOME, 1'b0};
    else if (c.no_home)   r = '{CODE_NO_HOME, BLINK_HOME, 1'b0};
    else if (c.aux_miss)  r = '{CODE_AUX_MISS, BLINK_HOME, 1'b0};
    else if (c.ofs_lim)   r = '{CODE_OFS_LIM, BLINK_HOME, 1'b0};
    else if (c.param_err) r = '{CODE_PARAM, BLINK_HOME, 1'b0};
    else if (c.panic)     r = '{CODE_PANIC, BLINK_PANIC, !keep_sel};
    else if (c.deviation) r = '{CODE_DEVIATION, BLINK_DEV, !keep_sel};
    else if (c.hw_ot)     r = '{CODE_HW_OT, BLINK_PANIC, !keep_sel};
    else if (c.sw_ot)     r = '{CODE_SW_OT, BLINK_PANIC, !keep_sel};
    return r;
  endfunction : classify

  // limit inputs after contact polarity
  assign lim_act = limit_contact_polarity ? ~travel_limit_in : travel_limit_in;

  // homing progress: home and auxiliary sightings, limits touched
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      home_seen_q <= 1'b0;
      aux_seen_q  <= 1'b0;
      lim_hit_q   <= 2'b00;
      lim_prev_q  <= 2'b00;
    end else begin
      lim_prev_q <= lim_act;
      if (!homing_active) begin
        home_seen_q <= 1'b0;
        aux_seen_q  <= 1'b0;
        lim_hit_q   <= 2'b00;
      end else begin
        home_seen_q <= home_seen_q | home_sensor_in;
        lim_hit_q   <= lim_hit_q | lim_act;
        // auxiliary signal counts only together with home sensor
        if (home_sensor_in && (slot_sensor_in || timing_position_sig || index_pulse_in)) begin
          aux_seen_q <= 1'b1;
        end
      end
    end
  end

  // overload accumulator, saturating
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      load_acc_q <= '0;
    end else if (fault_clear_in && latched_q) begin
      load_acc_q <= '0; // emptied while clear is held, so the off edge sees no overload
    end else if (!load_acc_q[LOAD_W]) begin
      load_acc_q <= load_acc_q + {1'b0, load_excess};
    end
  end

  // cause detection
  always_comb begin
    cause           = '0;
    cause.lim_both  = &lim_act;
    cause.lim_rev   = homing_active && (seek_dir_pos ? lim_act[0] : lim_act[1]);
    cause.home_fail = homing_active && (lim_act != lim_prev_q) && (&lim_hit_q == 1'b0)
                      && home_seen_q && (lim_act != 2'b00);
    cause.no_home   = homing_active && (&lim_hit_q) && !home_seen_q;
    cause.aux_miss  = homing_active && (homing_method_select != 2'b00) && home_seen_q
                      && !home_sensor_in && !aux_seen_q;
    cause.ofs_lim   = offset_move_active && (|lim_act);
    cause.param_err = motion_start && motion_param_bad;
    cause.deviation = deviation_action && (deviation_abs >= deviation_threshold);
    cause.panic     = emergency_halt || emergency_halt_cmd;
    cause.hw_ot     = moving && !homing_active && !offset_move_active && (|lim_act);
    cause.sw_ot     = sw_limit_enable && (cmd_position > sw_limit_pos
                      || cmd_position < sw_limit_neg);
    cause.overheat  = drive_temp > drive_temp_limit;
    cause.overload  = load_acc_q > {1'b0, overload_limit};
    cause.overvolt  = supply_over;
    cause.nvmem     = nvmem_corrupt;
    cause.sys_err   = internal_state_bad;
    cause.mem_err   = mem_access_fail;
    cause.seq_err   = seq_code_bad;
    cls             = classify(cause, fault_action_select);
  end

  // clear input falling edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clr_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= fault_clear_in;
    end
  end
  assign clr_fall = clr_prev_q && !fault_clear_in;

  // alarm latch: first alarm held until cleared; a new cause wins over a clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      latched_q <= 1'b0;
      code_q    <= CODE_NONE;
      blinks_q  <= BLINK_NONE;
      cut_q     <= 1'b0;
    end else if (cls.code != CODE_NONE && (!latched_q || clr_fall)) begin
      latched_q <= 1'b1;
      code_q    <= cls.code;
      blinks_q  <= cls.blinks;
      cut_q     <= cls.cut_current;
    end else if (clr_fall) begin
      latched_q <= 1'b0;
      code_q    <= CODE_NONE;
      blinks_q  <= BLINK_NONE;
      cut_q     <= 1'b0;
    end
  end

  // outputs from latched state
  assign alarm_active = latched_q;
  assign alarm_code   = code_q;
  assign alarm_blinks = blinks_q;
  assign fault_output = !latched_q;
  assign stop_motion  = latched_q;
  assign cut_current  = cut_q;
  assign alarm_led    = led_q_out;

  // led blink sequencer, repeats group until cleared
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      led_q     <= LED_IDLE;
      tmr_q     <= '0;
      pulse_q   <= BLINK_NONE;
      led_q_out <= 1'b0;
    end else begin
      case (led_q)
        LED_IDLE: begin
          led_q_out <= 1'b0;
          tmr_q     <= '0;
          pulse_q   <= BLINK_NONE;
          if (latched_q && blinks_q == BLINK_STEADY) begin
            led_q_out <= 1'b1;
          end else if (latched_q) begin
            led_q     <= LED_ON;
            led_q_out <= 1'b1;
          end
        end
        LED_ON: begin
          if (!latched_q || blinks_q == BLINK_STEADY) begin
            led_q     <= LED_IDLE;
            led_q_out <= latched_q; // re-latched internal error goes steady at once
          end else if (tmr_q == BLINK_LAST) begin
            tmr_q     <= '0;
            led_q     <= LED_OFF;
            led_q_out <= 1'b0;
            pulse_q   <= pulse_q + 4'h1;
          end else begin
            tmr_q <= tmr_q + CNT_W'(1);
          end
        end
        LED_OFF: begin
          if (!latched_q || blinks_q == BLINK_STEADY) begin
            led_q     <= LED_IDLE;
            led_q_out <= latched_q;
          end else if (tmr_q == BLINK_LAST) begin
            tmr_q <= '0;
            if (pulse_q >= blinks_q) begin
              led_q <= LED_GAP;
            end else begin
              led_q     <= LED_ON;
              led_q_out <= 1'b1;
            end
          end else begin
            tmr_q <= tmr_q + CNT_W'(1);
          end
        end
        default: begin
          if (!latched_q || blinks_q == BLINK_STEADY) begin
            led_q     <= LED_IDLE;
            led_q_out <= latched_q;
          end else if (tmr_q == GAP_LAST) begin
            tmr_q     <= '0;
            pulse_q   <= BLINK_NONE;
            led_q     <= LED_ON;
            led_q_out <= 1'b1;
          end else begin
            tmr_q <= tmr_q + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // alarm history write pointer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      log_wp_q <= 3'h0;
    end else if (cls.code != CODE_NONE && !latched_q) begin
      log_wp_q <= log_wp_q + 3'h1;
    end
  end

  mac_log_mem #(
    .DEPTH (LOG_DEPTH),
    .AW    (3)
  ) u_log (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wr_en    (cls.code != CODE_NONE && !latched_q),
    .wr_addr  (log_wp_q),
    .wr_data  (cls.code),
    .rd_addr  (log_rd_addr),
    .rd_data  (log_rd_data)
  );

  // assertions
  sequence clr_pulse_s;
    fault_clear_in ##1 !fault_clear_in;
  endsequence

  both_limits_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (&lim_act) && !latched_q && (classify(cause, fault_action_select).code == CODE_LIM_BOTH)
    |=> alarm_code == CODE_LIM_BOTH && stop_motion)
    else $error("both limits did not latch 0x60");
  home_group_a: assert property (@(posedge core_clk) disable iff (!rstn)
    latched_q && code_q[7:4] == 4'h6 && code_q != CODE_PANIC && code_q != CODE_HW_OT
    && code_q != CODE_SW_OT |-> blinks_q == BLINK_HOME && stop_motion)
    else $error("homing group blink or stop wrong");
  panic_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
    emergency_halt && !latched_q && cls.code == CODE_PANIC
    |=> alarm_code == CODE_PANIC && alarm_blinks == BLINK_PANIC)
    else $error("panic did not latch 0x68");
  overheat_cut_a: assert property (@(posedge core_clk) disable iff (!rstn)
    latched_q && (code_q == CODE_OVERHEAT || code_q == CODE_NVMEM || code_q == CODE_SYS)
    |-> cut_current)
    else $error("current not cut");
  fault_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(latched_q) |-> !fault_output && stop_motion)
    else $error("fault output not off on alarm");
  clear_fall_a: assert property (@(posedge core_clk) disable iff (!rstn)
    clr_pulse_s and (latched_q ##1 (cls.code == CODE_NONE)) |=> !alarm_active)
    else $error("clear on falling edge failed");
  code_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    latched_q && !clr_fall |=> $stable(alarm_code))
    else $error("alarm code changed without clear");
  steady_led_a: assert property (@(posedge core_clk) disable iff (!rstn)
    latched_q && blinks_q == BLINK_STEADY ##1 latched_q |-> alarm_led)
    else $error("internal error led not steady");
  keep_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(latched_q) && code_q == CODE_DEVIATION |-> cut_current == !$past(fault_action_select))
    else $error("deviation current action wrong");
endmodule : mac_alarm_classifier

// ==== test/mac_limit_model.sv ====
// far-side limit sensor pair with selectable contact polarity
`timescale 1ns/1ps
module mac_limit_model
  import mac_pkg::*;
(
  input  wire logic       limit_contact_polarity,
  input  wire logic       want_pos,
  input  wire logic       want_neg,
  output logic      [1:0] travel_limit_in
);
  // normally closed contacts read low when tripped
  assign travel_limit_in = {want_pos, want_neg} ^ {2{limit_contact_polarity}};
endmodule : mac_limit_model

// ==== test/tb.sv ====
// self-checking bench for the alarm classifier
`timescale 1ns/1ps
module tb;
  import mac_pkg::*;
  logic core_clk, rstn, want_pos, want_neg, limit_contact_polarity;
  logic [1:0] travel_limit_in, homing_method_select;
  logic home_sensor_in, slot_sensor_in, timing_position_sig, index_pulse_in;
  logic homing_active, seek_dir_pos, offset_move_active, moving, motion_start;
  logic motion_param_bad, deviation_action, emergency_halt, emergency_halt_cmd;
  logic fault_action_select, sw_limit_enable, supply_over, nvmem_corrupt;
  logic internal_state_bad, mem_access_fail, seq_code_bad, fault_clear_in;
  logic [31:0] deviation_abs, deviation_threshold;
  logic signed [31:0] cmd_position, sw_limit_pos, sw_limit_neg;
  logic [9:0] drive_temp, drive_temp_limit;
  logic [23:0] load_excess, overload_limit;
  logic [2:0] log_rd_addr;
  logic fault_output, alarm_active, stop_motion, cut_current, alarm_led;
  logic [7:0] alarm_code, log_rd_data;
  logic [3:0] alarm_blinks;
  int err_total, n_checks, cyc;
  mac_class_t exp_tab [16];

  mac_alarm_classifier #(.BLINK_CNT(4), .GAP_CNT(10)) dut (.*);
  mac_limit_model lim (.*);

  // clock source
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  // one cause per index, v asserts or withdraws it
  task automatic set_cause(int k, logic v);
    case (k)
      0: emergency_halt = v;
      1: emergency_halt_cmd = v;
      2: deviation_abs = v ? 32'h64 : 32'h0;
      3: drive_temp = v ? 10'h101 : 10'h0;
      4: load_excess = v ? 24'h10 : 24'h0;
      5: supply_over = v;
      6: nvmem_corrupt = v;
      7: internal_state_bad = v;
      8: mem_access_fail = v;
      9: seq_code_bad = v;
      10: {want_pos, want_neg} = {v, v};
      11: {moving, want_pos} = {v, v};
      12: {sw_limit_enable, cmd_position} = {v, v ? 32'sh101 : 32'sh0};
      13: {motion_start, motion_param_bad} = {v, v};
      14: {offset_move_active, want_pos} = {v, v};
      default: {homing_active, want_neg} = {v, v};
    endcase
  endtask : set_cause

  // led: count one blink group between gaps, or steady on
  task automatic led_check(logic [3:0] bl);
    int low, rises, phase;
    logic prev;
    low = 0; rises = 0; phase = 0; prev = 1'b0;
    for (int i = 0; i < 400 && phase < 2; i++) begin
      @(posedge core_clk); #1;
      if (alarm_led && !prev && phase == 1) rises++;
      low = alarm_led ? 0 : low + 1;
      if (low == 9) phase++;
      prev = alarm_led;
    end
    if (bl == BLINK_STEADY) rises = (phase == 0) ? 15 : 0;
    cmp8("led blinks", {4'h0, bl}, rises[7:0]);
  endtask : led_check

  task automatic expect_alarm(mac_class_t e);
    repeat (8) @(posedge core_clk);
    #1;
    cmp8("code", e.code, alarm_code);
    cmp8("blinks", {4'h0, e.blinks}, {4'h0, alarm_blinks});
    cmp8("cut", {7'h0, e.cut_current}, {7'h0, cut_current});
    cmp8("fault_output", 8'h0, {7'h0, fault_output});
    cmp8("stop", 8'h1, {7'h0, stop_motion});
    led_check(e.blinks);
  endtask : expect_alarm

  // pulse clear on then off; latch holds until the off edge
  task automatic clear_alarm();
    @(posedge core_clk); #1 fault_clear_in = 1'b1;
    @(posedge core_clk); #1 fault_clear_in = 1'b0;
    cmp8("held", 8'h1, {7'h0, alarm_active});
    repeat (2) @(posedge core_clk);
    #1;
    cmp8("cleared", 8'h0, {7'h0, alarm_active});
    cmp8("fault_output", 8'h1, {7'h0, fault_output});
  endtask : clear_alarm

  initial begin
    exp_tab = '{
      '{CODE_PANIC, BLINK_PANIC, 1'b0},
      '{CODE_PANIC, BLINK_PANIC, 1'b1},
      '{CODE_DEVIATION, BLINK_DEV, 1'b0},
      '{CODE_OVERHEAT, BLINK_LOAD, 1'b1},
      '{CODE_OVERLOAD, BLINK_LOAD, 1'b1},
      '{CODE_OVERVOLT, BLINK_VOLT, 1'b1},
      '{CODE_NVMEM, BLINK_NVMEM, 1'b1},
      '{CODE_SYS, BLINK_STEADY, 1'b1},
      '{CODE_MEM, BLINK_STEADY, 1'b1},
      '{CODE_SEQ, BLINK_STEADY, 1'b1},
      '{CODE_LIM_BOTH, BLINK_HOME, 1'b0},
      '{CODE_HW_OT, BLINK_PANIC, 1'b0},
      '{CODE_SW_OT, BLINK_PANIC, 1'b0},
      '{CODE_PARAM, BLINK_HOME, 1'b0},
      '{CODE_OFS_LIM, BLINK_HOME, 1'b0},
      '{CODE_LIM_REV, BLINK_HOME, 1'b0}};
    {rstn, want_pos, want_neg, home_sensor_in, slot_sensor_in} = '0;
    {timing_position_sig, index_pulse_in, homing_method_select, homing_active} = '0;
    {offset_move_active, moving, motion_start, motion_param_bad} = '0;
    {emergency_halt, emergency_halt_cmd, sw_limit_enable, supply_over} = '0;
    {nvmem_corrupt, internal_state_bad, mem_access_fail, seq_code_bad} = '0;
    {fault_clear_in, log_rd_addr, deviation_abs, drive_temp, load_excess} = '0;
    {limit_contact_polarity, seek_dir_pos, deviation_action} = 3'h7;
    fault_action_select = 1'b1;
    deviation_threshold = 32'h64;
    cmd_position = 32'sh0;
    sw_limit_pos = 32'sh100;
    sw_limit_neg = -32'sh100;
    drive_temp_limit = 10'h100;
    overload_limit = 24'h40;
    repeat (5) @(posedge core_clk);
    #1;
    cmp8("reset fault_output", 8'h1, {7'h0, fault_output});
    cmp8("reset code", 8'h0, alarm_code);
    rstn = 1'b1;
    for (int k = 0; k < 16; k++) begin
      fault_action_select = (k != 1);
      set_cause(k, 1'b1);
      expect_alarm(exp_tab[k]);
      set_cause(k, 1'b0);
      clear_alarm();
    end
    // homing: limit change after home seen, before both limits touched
    {homing_active, home_sensor_in} = 2'b11;
    @(posedge core_clk); #1 {home_sensor_in, want_pos} = 2'b01;
    expect_alarm(mac_class_t'{CODE_HOME_FAIL, BLINK_HOME, 1'b0});
    {homing_active, want_pos} = 2'b00;
    clear_alarm();
    // homing: both limits touched, seek reversed, home sensor never seen
    {homing_active, want_pos} = 2'b11;
    @(posedge core_clk); #1 {want_pos, seek_dir_pos, want_neg} = 3'b001;
    expect_alarm(mac_class_t'{CODE_NO_HOME, BLINK_HOME, 1'b0});
    {homing_active, seek_dir_pos, want_neg} = 3'b010;
    clear_alarm();
    // homing: method needs an auxiliary signal, home drops without one
    {homing_active, homing_method_select, home_sensor_in} = 4'b1011;
    @(posedge core_clk); #1 home_sensor_in = 1'b0;
    expect_alarm(mac_class_t'{CODE_AUX_MISS, BLINK_HOME, 1'b0});
    {homing_active, homing_method_select} = 3'b000;
    clear_alarm();
    // a later cause must not replace the latched code
    emergency_halt = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 supply_over = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    cmp8("first kept", CODE_PANIC, alarm_code);
    {emergency_halt, supply_over} = 2'b00;
    clear_alarm();
    // history: sixteenth alarm raised sits in the last slot
    log_rd_addr = 3'h7;
    repeat (2) @(posedge core_clk);
    #1;
    cmp8("log entry", CODE_LIM_REV, log_rd_data);
    summarize();
  end
endmodule : tb
